/* rtl/rtb_timer.sv */
/*
 * Reload timer with baud select: 16-bit auto-reload timer with a
 * power-of-two prescaler, overflow flag and interrupt, plus serial-port
 * option bits that share the control register.
 * Assumes a single-cycle register port and a CPU that pulses isrAck when
 * it vectors to this timer's service routine.
 */
// Decided for this implementation: the address-and-strobe port.
//
// Behaviour
// - Overflow sets control bit 4 flag
// - Entering service routine clears overflow flag
// - Software may set or clear overflow flag
// - Run bit 3 halts or runs timer
// - Prescaler bits 2:0 divide by 2**code
// - Reload low byte holds bits 7:0
// - Reload high byte holds bits 15:8
// - Bit 5 picks port 0 baud source
// - Bit 7 doubles port 1 mode 2 baud
// - Bit 6 picks port 1 bit-7 access
`timescale 1ns/1ps
`default_nettype none
module rtb_timer #(
    parameter int COUNT_W = rtb_pkg::COUNT_W,
    parameter int PRESC_W = rtb_pkg::PRESC_W
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    // Register port
    input  wire logic [rtb_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [rtb_pkg::DATA_W-1:0] regWdata,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic      [rtb_pkg::DATA_W-1:0] regRdata,
    // CPU interrupt vectoring
    input  wire logic                       isrAck,
    // Timer state
    output logic                            overflowTick,
    output logic                            irq,
    // Serial-port option bits
    output logic                            port0BaudSourceSelect,
    output logic                            port1BaudDouble,
    output logic                            port1ErrorAccessSelect
);
    // Refused at elaboration: the reload bytes and control fields fix these sizes
    if (COUNT_W != 2 * rtb_pkg::DATA_W) begin : g_bad_count_w
        $error("rtb_timer: COUNT_W must be two bytes");
    end
    if (PRESC_W != rtb_pkg::PRESC_W) begin : g_bad_presc_w
        $error("rtb_timer: PRESC_W fixed by control layout");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [rtb_pkg::DATA_W-1:0] timerCtrl;
    logic [rtb_pkg::DATA_W-1:0] reloadLowByte;
    logic [rtb_pkg::DATA_W-1:0] reloadHighByte;
    logic [rtb_pkg::IST_W-1:0]  intStatus;
    logic [rtb_pkg::IST_W-1:0]  intMask;
    logic [COUNT_W-1:0]         count;
    logic                       overflow;
    logic                       tick;
    logic                       runControl;
    logic [PRESC_W-1:0]         prescaleSelect;
    logic                       wrCtrl;
    logic                       wrReloadLo;
    logic                       wrReloadHi;
    logic                       wrReloadLive;
    logic [rtb_pkg::DATA_W-1:0] next_regRdata;
    logic [rtb_pkg::IST_W-1:0]  eventSet;

    assign runControl     = timerCtrl[rtb_pkg::BIT_RUN];
    assign prescaleSelect = timerCtrl[rtb_pkg::PRESC_LSB +: PRESC_W];
    assign wrCtrl         = regWrite && (regAddr == rtb_pkg::OFF_CTRL);
    assign wrReloadLo     = regWrite && (regAddr == rtb_pkg::OFF_RELOAD_LO);
    assign wrReloadHi     = regWrite && (regAddr == rtb_pkg::OFF_RELOAD_HI);
    // A reload write while running is unpredictable; flag it for software
    assign wrReloadLive   = (wrReloadLo || wrReloadHi) && runControl;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and counter
    rtb_prescaler #(
        .SEL_W (PRESC_W),
        .DIV_W (rtb_pkg::DIV_W)
    ) uPrescaler (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .enable  (runControl),
        .select  (prescaleSelect),
        .tick    (tick)
    );

    rtb_counter #(
        .WIDTH (COUNT_W)
    ) uCounter (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .step        (tick),
        .reloadValue ({reloadHighByte, reloadLowByte}),
        .count       (count),
        .overflow    (overflow)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timerCtrl <= rtb_pkg::RST_BYTE;
        end else begin
            if (wrCtrl) begin
                timerCtrl <= regWdata;
            end
            // Hardware set wins over both software clear and ISR clear
            if (overflow) begin
                timerCtrl[rtb_pkg::BIT_OVF] <= 1'b1;
            end else if (isrAck) begin
                timerCtrl[rtb_pkg::BIT_OVF] <= 1'b0;
            end else if (wrCtrl) begin
                timerCtrl[rtb_pkg::BIT_OVF] <= regWdata[rtb_pkg::BIT_OVF];
            end
        end
    end

    // Reload bytes; writes while running are still stored
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reloadLowByte  <= rtb_pkg::RST_BYTE;
            reloadHighByte <= rtb_pkg::RST_BYTE;
        end else begin
            if (wrReloadLo) begin
                reloadLowByte <= regWdata;
            end
            if (wrReloadHi) begin
                reloadHighByte <= regWdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    always_comb begin
        eventSet = rtb_pkg::RST_IST;
        eventSet[rtb_pkg::IST_OVF]    = overflow;
        eventSet[rtb_pkg::IST_WR_RUN] = wrReloadLive;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intStatus <= rtb_pkg::RST_IST;
        end else if (regWrite && (regAddr == rtb_pkg::OFF_INT_STAT)) begin
            intStatus <= (intStatus & ~regWdata[rtb_pkg::IST_W-1:0]) | eventSet;
        end else begin
            intStatus <= intStatus | eventSet;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            intMask <= rtb_pkg::RST_IST;
        end else if (regWrite && (regAddr == rtb_pkg::OFF_INT_MASK)) begin
            intMask <= regWdata[rtb_pkg::IST_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        next_regRdata = rtb_pkg::RST_BYTE;
        case (regAddr)
            rtb_pkg::OFF_CTRL:      next_regRdata = timerCtrl;
            rtb_pkg::OFF_RELOAD_LO: next_regRdata = reloadLowByte;
            rtb_pkg::OFF_RELOAD_HI: next_regRdata = reloadHighByte;
            rtb_pkg::OFF_INT_STAT:  next_regRdata = {{(rtb_pkg::DATA_W-rtb_pkg::IST_W){1'b0}},
                                                     intStatus};
            rtb_pkg::OFF_INT_MASK:  next_regRdata = {{(rtb_pkg::DATA_W-rtb_pkg::IST_W){1'b0}},
                                                     intMask};
            rtb_pkg::OFF_COUNT_LO:  next_regRdata = count[rtb_pkg::DATA_W-1:0];
            rtb_pkg::OFF_COUNT_HI:  next_regRdata = count[COUNT_W-1:rtb_pkg::DATA_W];
            default:                next_regRdata = rtb_pkg::RST_BYTE;
        endcase
    end

    // Data shows only in the cycle after a read strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= rtb_pkg::RST_BYTE;
        end else if (regRead) begin
            regRdata <= next_regRdata;
        end else begin
            regRdata <= rtb_pkg::RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            overflowTick <= 1'b0;
            irq          <= 1'b0;
        end else begin
            overflowTick <= overflow;
            irq          <= |(intStatus & intMask);
        end
    end

    // Serial-port option bits mirror the control register one clock later
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            port0BaudSourceSelect  <= 1'b0;
            port1BaudDouble        <= 1'b0;
            port1ErrorAccessSelect <= 1'b0;
        end else begin
            port0BaudSourceSelect  <= timerCtrl[rtb_pkg::BIT_BAUD_SRC];
            port1BaudDouble        <= timerCtrl[rtb_pkg::BIT_BAUD_DBL];
            port1ErrorAccessSelect <= timerCtrl[rtb_pkg::BIT_ERR_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_overflow_sets_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        overflow |=> timerCtrl[rtb_pkg::BIT_OVF])
        else $error("overflow did not set flag");

    a_isr_clears_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        (isrAck && !overflow) |=> !timerCtrl[rtb_pkg::BIT_OVF])
        else $error("isr did not clear flag");

    a_sw_writes_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wrCtrl && !overflow && !isrAck)
        |=> timerCtrl[rtb_pkg::BIT_OVF] == $past(regWdata[rtb_pkg::BIT_OVF]))
        else $error("software flag write lost");

    a_halt_holds_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        !runControl |=> count == $past(count))
        else $error("count moved while halted");

    // A control write in the tick's cycle or the next one may stop or re-code the divider
    a_prescale_full_div: assert property (@(posedge sys_clk) disable iff (!rstn)
        (tick && !wrCtrl && prescaleSelect == PRESC_W'(1)) ##1 !wrCtrl
        |-> !tick ##1 tick)
        else $error("divide by two wrong");

    a_code0_every_clk: assert property (@(posedge sys_clk) disable iff (!rstn)
        (runControl && prescaleSelect == '0) |-> tick)
        else $error("code zero did not tick every clock");

    a_halt_no_tick: assert property (@(posedge sys_clk) disable iff (!rstn)
        !runControl |-> !tick)
        else $error("tick while halted");

    a_reload_on_ovf: assert property (@(posedge sys_clk) disable iff (!rstn)
        overflow |=> count == $past({reloadHighByte, reloadLowByte}))
        else $error("reload not applied");

    a_count_steps_up: assert property (@(posedge sys_clk) disable iff (!rstn)
        (tick && !overflow) |=> count == $past(count) + rtb_pkg::COUNT_ONE)
        else $error("count did not step");

    a_reload_lo_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        wrReloadLo |=> reloadLowByte == $past(regWdata))
        else $error("reload low write lost");

    a_reload_hi_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        wrReloadHi |=> reloadHighByte == $past(regWdata))
        else $error("reload high write lost");

    a_baud_bits_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
        wrCtrl |=> ##1 (port0BaudSourceSelect == $past(regWdata[rtb_pkg::BIT_BAUD_SRC], 2))
        && (port1BaudDouble == $past(regWdata[rtb_pkg::BIT_BAUD_DBL], 2))
        && (port1ErrorAccessSelect == $past(regWdata[rtb_pkg::BIT_ERR_SEL], 2)))
        else $error("serial option bits wrong");

    a_live_write_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
        wrReloadLive |=> intStatus[rtb_pkg::IST_WR_RUN])
        else $error("live reload write not flagged");

    a_ovf_sets_status: assert property (@(posedge sys_clk) disable iff (!rstn)
        overflow |=> intStatus[rtb_pkg::IST_OVF])
        else $error("overflow status not set");

    a_ovf_pulse_out: assert property (@(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> overflowTick == $past(overflow))
        else $error("overflow pulse wrong");

    // Interrupt lags the status by one clock so that it leaves a flip-flop
    a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> irq == |($past(intStatus) & $past(intMask)))
        else $error("interrupt does not follow masked status");

    a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        !regRead |=> regRdata == rtb_pkg::RST_BYTE)
        else $error("read data shown without a read");
endmodule : rtb_timer
`default_nettype wire

/* common/rtb_pkg.sv */
/*
 * Constants for the reload timer with baud select: register offsets,
 * control field positions, reset values and widths.
 * Assumes an 8-bit special-function-register port with byte offsets.
 */
package rtb_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          COUNT_W       = 16;
    localparam int          PRESC_W       = 3;
    localparam int          DIV_W         = 7;
    // Register offsets
    localparam logic [7:0]  OFF_CTRL      = 8'hC4;
    localparam logic [7:0]  OFF_RELOAD_LO = 8'hC5;
    localparam logic [7:0]  OFF_RELOAD_HI = 8'hC6;
    localparam logic [7:0]  OFF_INT_STAT  = 8'hC8;
    localparam logic [7:0]  OFF_INT_MASK  = 8'hC9;
    localparam logic [7:0]  OFF_COUNT_LO  = 8'hCA;
    localparam logic [7:0]  OFF_COUNT_HI  = 8'hCB;
    // Control field positions
    localparam int          BIT_BAUD_DBL  = 7;
    localparam int          BIT_ERR_SEL   = 6;
    localparam int          BIT_BAUD_SRC  = 5;
    localparam int          BIT_OVF       = 4;
    localparam int          BIT_RUN       = 3;
    localparam int          PRESC_LSB     = 0;
    // Interrupt status bits
    localparam int          IST_OVF       = 0;
    localparam int          IST_WR_RUN    = 1;
    localparam int          IST_W         = 2;
    // Reset values and counting constants
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [1:0]  RST_IST       = 2'h0;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE     = 16'h0001;
    localparam logic [6:0]  DIV_ONE       = 7'h01;
    localparam logic [6:0]  DIV_ZERO      = 7'h00;
endpackage : rtb_pkg

/* rtl/rtb_prescaler.sv */
/*
 * Power-of-two prescaler: a free-running divider that yields one tick
 * every 2**select clocks while enabled.
 * Assumes select is steady while running.
 */
`timescale 1ns/1ps
`default_nettype none
module rtb_prescaler #(
    parameter int SEL_W = rtb_pkg::PRESC_W,
    parameter int DIV_W = rtb_pkg::DIV_W
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             enable,
    input  wire logic [SEL_W-1:0] select,
    // Output
    output logic                  tick
);
    // Refused at elaboration: the divider must reach exactly the largest division
    if (DIV_W != (1 << SEL_W) - 1) begin : g_bad_div_w
        $error("rtb_prescaler: DIV_W must be 2**SEL_W-1");
    end

    logic [DIV_W-1:0] divCount;
    logic [DIV_W-1:0] divMask;

    // Mask of low bits that must all be one before a tick is due
    assign divMask = DIV_W'((DIV_W'(1) << select) - DIV_W'(1));
    assign tick    = enable && ((divCount & divMask) == divMask);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            divCount <= DIV_W'(rtb_pkg::DIV_ZERO);
        end else if (!enable) begin
            divCount <= DIV_W'(rtb_pkg::DIV_ZERO);
        end else begin
            divCount <= divCount + DIV_W'(rtb_pkg::DIV_ONE);
        end
    end
endmodule : rtb_prescaler
`default_nettype wire

/* rtl/rtb_counter.sv */
/*
 * Up counter with reload on overflow.
 * Assumes reloadValue is held steady while counting.
 */
`timescale 1ns/1ps
`default_nettype none
module rtb_counter #(
    parameter int WIDTH = rtb_pkg::COUNT_W
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             step,
    input  wire logic [WIDTH-1:0] reloadValue,
    // State
    output logic      [WIDTH-1:0] count,
    output logic                  overflow
);
    // Refused at elaboration: a one-bit counter cannot reload meaningfully
    if (WIDTH < 2) begin : g_bad_width
        $error("rtb_counter: WIDTH too small");
    end

    assign overflow = step && (count == {WIDTH{1'b1}});

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (overflow) begin
            count <= reloadValue;
        end else if (step) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule : rtb_counter
`default_nettype wire

/* testbench/rtb_timer_tb_top.sv */
/*
 * Self-checking bench for the reload timer with baud select: register
 * reset values and access, overflow and reload, prescaler codes, flag
 * handling, interrupt masking and the serial option bits.
 * Assumes the register port answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module rtb_timer_tb_top;
    localparam logic [7:0] A_CTRL = rtb_pkg::OFF_CTRL;
    localparam logic [7:0] A_RLO  = rtb_pkg::OFF_RELOAD_LO;
    localparam logic [7:0] A_RHI  = rtb_pkg::OFF_RELOAD_HI;
    localparam logic [7:0] A_IST  = rtb_pkg::OFF_INT_STAT;
    localparam logic [7:0] A_IMSK = rtb_pkg::OFF_INT_MASK;
    localparam logic [7:0] A_CLO  = rtb_pkg::OFF_COUNT_LO;
    localparam logic [7:0] A_CHI  = rtb_pkg::OFF_COUNT_HI;

    logic       sysClk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regRdata;
    logic       isrAck = 1'b0;
    logic       overflowTick;
    logic       irq;
    logic       port0BaudSourceSelect;
    logic       port1BaudDouble;
    logic       port1ErrorAccessSelect;
    int         miscompares = 0;
    int         testsRun = 0;

    always #2.5 sysClk = ~sysClk;

    rtb_timer i_dut (
        .sys_clk                (sysClk),
        .rstn                   (rstn),
        .regAddr                (regAddr),
        .regWdata               (regWdata),
        .regWrite               (regWrite),
        .regRead                (regRead),
        .regRdata               (regRdata),
        .isrAck                 (isrAck),
        .overflowTick           (overflowTick),
        .irq                    (irq),
        .port0BaudSourceSelect  (port0BaudSourceSelect),
        .port1BaudDouble        (port1BaudDouble),
        .port1ErrorAccessSelect (port1ErrorAccessSelect)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge sysClk);
        #1;
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sysClk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sysClk);
        regWrite <= 1'b0;
    endtask : wr

    // Data is only valid in the single cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sysClk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sysClk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    task automatic wait_ovf(input int limit, output int n);
        n = 0;
        do begin
            @(posedge sysClk);
            #1;
            n++;
        end while (overflowTick !== 1'b1 && n < limit);
        if (overflowTick !== 1'b1) begin
            miscompares++;
            $display("MISMATCH overflowTick expected 1 seen 0 after %0d cycles", n);
            test_done();
        end
    endtask : wait_ovf

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] d;
        int         i;
        rd(A_CTRL, d);
        chk("ctrl reset", d, 8'h00);
        rd(A_RLO, d);
        chk("reload low reset", d, 8'h00);
        rd(A_RHI, d);
        chk("reload high reset", d, 8'h00);
        rd(A_IST, d);
        chk("status reset", d, 8'h00);
        chk("irq reset", irq, 1'b0);
        wr(8'hD0, 8'hFF);
        rd(8'hD0, d);
        chk("unmapped read", d, 8'h00);
        for (i = 5; i < 8; i++) begin
            wr(A_CTRL, 8'h01 << i);
            idle(2);
            chk("option bits", {port1BaudDouble, port1ErrorAccessSelect,
                port0BaudSourceSelect}, 3'h1 << (i - 5));
            rd(A_CTRL, d);
            chk("ctrl readback", d, 8'h01 << i);
        end
        wr(A_CTRL, 8'h00);
        $display("register test done");
    endtask : t_regs

    // First wrap walks the whole 16-bit range from zero
    task automatic t_overflow();
        logic [7:0] d;
        logic [7:0] e;
        int         n;
        wr(A_RLO, 8'hF0);
        wr(A_RHI, 8'hFF);
        rd(A_RLO, d);
        chk("reload low", d, 8'hF0);
        rd(A_RHI, d);
        chk("reload high", d, 8'hFF);
        wr(A_CTRL, 8'h08);
        wait_ovf(70000, n);
        rd(A_CTRL, d);
        chk("overflow flag set", d, 8'h18);
        wait_ovf(100, n);
        wait_ovf(100, n);
        chk("reload period", n, 16'd16);
        rd(A_CHI, d);
        chk("count high after reload", d, 8'hFF);
        wr(A_RLO, 8'hF0);
        rd(A_IST, d);
        chk("write while running", d[1], 1'b1);
        wr(A_CTRL, 8'h00);
        rd(A_CLO, d);
        idle(20);
        rd(A_CLO, e);
        chk("halted count", e, d);
        $display("overflow test done");
    endtask : t_overflow

    task automatic t_prescale();
        int         code;
        int         n;
        for (code = 0; code < 8; code++) begin
            wr(A_CTRL, 8'h00);
            wr(A_CTRL, 8'h08 | code[7:0]);
            wait_ovf(5000, n);
            wait_ovf(5000, n);
            chk("prescaled period", n, 16'd16 << code);
        end
        wr(A_CTRL, 8'h00);
        $display("prescale test done");
    endtask : t_prescale

    task automatic t_flag();
        logic [7:0] d;
        wr(A_CTRL, 8'h10);
        rd(A_CTRL, d);
        chk("flag set by software", d, 8'h10);
        wr(A_CTRL, 8'h00);
        rd(A_CTRL, d);
        chk("flag cleared by software", d, 8'h00);
        wr(A_CTRL, 8'h10);
        @(posedge sysClk);
        isrAck <= 1'b1;
        @(posedge sysClk);
        isrAck <= 1'b0;
        rd(A_CTRL, d);
        chk("flag cleared by service entry", d, 8'h00);
        $display("flag test done");
    endtask : t_flag

    task automatic t_irq();
        logic [7:0] d;
        int         n;
        wr(A_IST, 8'h03);
        rd(A_IST, d);
        chk("status cleared", d, 8'h00);
        wr(A_IMSK, 8'h01);
        rd(A_IMSK, d);
        chk("mask readback", d, 8'h01);
        wr(A_CTRL, 8'h08);
        wait_ovf(100, n);
        // The interrupt output trails the status bit by one clock
        idle(1);
        chk("irq with overflow", irq, 1'b1);
        wr(A_CTRL, 8'h00);
        wr(A_IMSK, 8'h00);
        idle(2);
        chk("irq masked", irq, 1'b0);
        wr(A_IMSK, 8'h01);
        idle(2);
        chk("irq unmasked", irq, 1'b1);
        wr(A_IST, 8'h01);
        idle(2);
        chk("irq after clear", irq, 1'b0);
        rd(A_IST, d);
        chk("status after clear", d, 8'h00);
        $display("interrupt test done");
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sysClk);
        rstn <= 1'b1;
        t_regs();
        t_overflow();
        t_prescale();
        t_flag();
        t_irq();
        test_done();
    end
endmodule : rtb_timer_tb_top
`default_nettype wire
